// *** include/adc_aux_pkg.sv ***
`default_nettype none
package adc_aux_pkg;
	localparam logic [11:0] OFS_PUMP_CTRL    = 12'h000;
	localparam logic [11:0] OFS_CHAN_SEL     = 12'h004;
	localparam logic [11:0] OFS_DIV_CTRL     = 12'h008;
	localparam logic [11:0] OFS_DIV_TIMING   = 12'h00C;
	localparam logic [11:0] OFS_IRQ_STATUS   = 12'h010;
	localparam logic [11:0] OFS_IRQ_MASK     = 12'h014;
	localparam int          BIT_PUMP_EN      = 0;
	localparam int          BIT_PUMP_RDY     = 1;
	localparam int          BIT_DIV_START    = 0;
	localparam int          BIT_DIV_DIFF     = 1;
	localparam int          BIT_DIV_HOLDHI   = 2;
	localparam int          BIT_DIV_BUSY     = 3;
	localparam int          BIT_EV_PUMP      = 0;
	localparam int          BIT_EV_CONV      = 1;
	localparam int          BIT_EV_DONE      = 2;
	localparam logic [5:0]  CHAN_RESET       = 6'h00;
	localparam logic [7:0]  PRE_RESET        = 8'h10;
	localparam logic [7:0]  ACQ_RESET        = 8'h20;
	localparam int          PUMP_START_NS    = 10000;
	localparam int          CLK_NS           = 10;
	localparam int          PUMP_START_CYC   = (PUMP_START_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0]  IRQ_RESET        = 3'h0;
endpackage
`default_nettype wire

// *** hw/adc_pump_cvd_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_pump_cvd_sequencer
#(
	parameter int unsigned PUMP_CYCLES = adc_aux_pkg::PUMP_START_CYC
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        conv_done,
	output logic             pump_on,
	output logic             hold_connect,
	output logic             hold_pre_high,
	output logic             hold_pre_low,
	output logic             sense_pre_high,
	output logic             sense_pre_low,
	output logic             conv_start,
	output logic [5:0]       chan_sel,
	output logic             chan_valid,
	output logic             irq
);
	import adc_aux_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_DISC, ST_PRE, ST_ACQ, ST_CONV, ST_WAIT} seq_t;

	seq_t        state_r;
	logic        pump_en_r;
	logic        pump_rdy_r;
	logic [31:0] pump_cnt_r;
	logic [5:0]  chan_r;
	logic        diff_r;
	logic        holdhi_r;
	logic        phase_r;
	logic [7:0]  pre_len_r;
	logic [7:0]  acq_len_r;
	logic [7:0]  cnt_r;
	logic [2:0]  stat_r;
	logic [2:0]  mask_r;
	logic        acc;
	logic        wr_en;
	logic        rd_en;
	logic        start_req;
	logic        ev_pump;
	logic        ev_conv;
	logic        ev_done;
	logic        hold_hi;
	logic [31:0] rd_nxt;
	logic        addr_ok;

	// Reserved codes connect nothing
	function automatic logic chan_ok(input logic [5:0] c);
		chan_ok = (c <= 6'h1F) || (c >= 6'h20 && c <= 6'h22)
			|| (c >= 6'h28 && c <= 6'h2F) || (c >= 6'h3B);
	endfunction

	// Hold capacitor is cut off from the sensor path in these states
	function automatic logic isolated(input seq_t s);
		isolated = s == ST_DISC || s == ST_PRE;
	endfunction

	function automatic logic precharging(input seq_t s);
		precharging = s == ST_PRE;
	endfunction

	// Registers change only at the edge that completes the access
	assign acc       = psel && penable;
	assign wr_en     = acc && pwrite && pready;
	assign rd_en     = acc && !pwrite && pready;
	assign start_req = wr_en && paddr == OFS_DIV_CTRL && pwdata[BIT_DIV_START];
	// Second pass swaps both precharge levels
	assign hold_hi   = holdhi_r ^ phase_r;
	assign ev_pump   = pump_en_r && !pump_rdy_r && pump_cnt_r == PUMP_CYCLES;
	assign ev_conv   = state_r == ST_WAIT && conv_done;
	assign ev_done   = ev_conv && (!diff_r || phase_r);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pump_en_r <= 1'b0;
		else if (wr_en && paddr == OFS_PUMP_CTRL)
			pump_en_r <= pwdata[BIT_PUMP_EN];
	end

	// Bits 31:6 of the word are dropped, so they read back as zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			chan_r <= CHAN_RESET;
		else if (wr_en && paddr == OFS_CHAN_SEL)
			chan_r <= pwdata[5:0];
	end

	// Mode bits frozen while a sequence runs, so a pass never changes level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			diff_r   <= 1'b0;
			holdhi_r <= 1'b0;
		end
		else if (wr_en && paddr == OFS_DIV_CTRL && state_r == ST_IDLE)
		begin
			diff_r   <= pwdata[BIT_DIV_DIFF];
			holdhi_r <= pwdata[BIT_DIV_HOLDHI];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_len_r <= PRE_RESET;
			acq_len_r <= ACQ_RESET;
		end
		else if (wr_en && paddr == OFS_DIV_TIMING)
		begin
			pre_len_r <= pwdata[7:0];
			acq_len_r <= pwdata[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_r <= IRQ_RESET;
		else if (wr_en && paddr == OFS_IRQ_MASK)
			mask_r <= pwdata[2:0];
	end

	// Start-up counter; ready drops the moment the pump is turned off
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pump_cnt_r <= 32'h00000000;
			pump_rdy_r <= 1'b0;
		end
		else if (!pump_en_r)
		begin
			pump_cnt_r <= 32'h00000000;
			pump_rdy_r <= 1'b0;
		end
		else if (!pump_rdy_r)
		begin
			pump_cnt_r <= pump_cnt_r + 32'h00000001;
			if (ev_pump)
				pump_rdy_r <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ST_IDLE;
			phase_r <= 1'b0;
			cnt_r   <= 8'h00;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					phase_r <= 1'b0;
					if (start_req)
						state_r <= ST_DISC;
				end
				// Phases count down to zero, so each lasts its length plus one
				ST_DISC:
				begin
					cnt_r   <= pre_len_r;
					state_r <= ST_PRE;
				end
				ST_PRE:
				begin
					if (cnt_r == 8'h00)
					begin
						cnt_r   <= acq_len_r;
						state_r <= ST_ACQ;
					end
					else
						cnt_r <= cnt_r - 8'h01;
				end
				ST_ACQ:
				begin
					if (cnt_r == 8'h00)
						state_r <= ST_CONV;
					else
						cnt_r <= cnt_r - 8'h01;
				end
				ST_CONV:
					state_r <= ST_WAIT;
				ST_WAIT:
				begin
					if (conv_done)
					begin
						if (diff_r && !phase_r)
						begin
							phase_r <= 1'b1;
							state_r <= ST_DISC;
						end
						else
							state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Registered analog controls keep the drive glitch-free
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_connect   <= 1'b1;
			hold_pre_high  <= 1'b0;
			hold_pre_low   <= 1'b0;
			sense_pre_high <= 1'b0;
			sense_pre_low  <= 1'b0;
		end
		else
		begin
			hold_connect   <= !isolated(state_r);
			hold_pre_high  <= precharging(state_r) && hold_hi;
			hold_pre_low   <= precharging(state_r) && !hold_hi;
			sense_pre_high <= precharging(state_r) && !hold_hi;
			sense_pre_low  <= precharging(state_r) && hold_hi;
		end
	end

	// One-cycle request; the converter latches it itself
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conv_start <= 1'b0;
		else
			conv_start <= state_r == ST_CONV;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pump_on <= 1'b0;
		else
			pump_on <= pump_en_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chan_sel   <= CHAN_RESET;
			chan_valid <= 1'b0;
		end
		else
		begin
			chan_sel   <= chan_r;
			chan_valid <= chan_ok(chan_r);
		end
	end

	// Set wins over read-clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_r <= IRQ_RESET;
		else
		begin
			// Only the bits already returned are cleared, so later events survive
			if (rd_en && paddr == OFS_IRQ_STATUS)
				stat_r <= (stat_r & ~prdata[2:0]) | {ev_done, ev_conv, ev_pump};
			else
				stat_r <= stat_r | {ev_done, ev_conv, ev_pump};
		end
	end

	// Registered level, one cycle behind status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(stat_r & mask_r);
	end

	always_comb
	begin
		rd_nxt  = 32'h00000000;
		addr_ok = 1'b1;
		unique case (paddr)
			OFS_PUMP_CTRL:  rd_nxt = {30'h0, pump_rdy_r, pump_en_r};
			OFS_CHAN_SEL:   rd_nxt = {26'h0, chan_r};
			OFS_DIV_CTRL:   rd_nxt = {28'h0, state_r != ST_IDLE, holdhi_r, diff_r, 1'b0};
			OFS_DIV_TIMING: rd_nxt = {16'h0, acq_len_r, pre_len_r};
			OFS_IRQ_STATUS: rd_nxt = {29'h0, stat_r};
			OFS_IRQ_MASK:   rd_nxt = {29'h0, mask_r};
			default:        addr_ok = 1'b0;
		endcase
	end

	// One wait state: pready answers in the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= acc && !pready;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= acc && !pready && !addr_ok;
	end

	// Data stands only while pready is high and reads zero otherwise
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else
			prdata <= (acc && !pwrite && !pready) ? rd_nxt : 32'h00000000;
	end
endmodule
`default_nettype wire

// *** dv/conv_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module conv_model
(
	input  wire logic pclk,
	input  wire logic conv_start,
	output logic      conv_done
);
	logic [1:0] d = 2'h0;
	initial conv_done = 1'h0;
	// Answers a few cycles late so the wait state is really used
	always @(posedge pclk)
	begin
		conv_done <= d == 2'h1;
		d <= conv_start ? 2'h3 : d - {1'h0, d != 2'h0};
	end
endmodule
`default_nettype wire

// *** dv/adc_seq_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_seq_monitor
import adc_aux_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pump_on,
	input wire logic        hold_connect,
	input wire logic        hold_pre_high,
	input wire logic        hold_pre_low,
	input wire logic        sense_pre_high,
	input wire logic        sense_pre_low,
	input wire logic        conv_start
);
	logic pre;
	assign pre = hold_pre_high | hold_pre_low | sense_pre_high | sense_pre_low;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_pump; psel && penable && pwrite && pready && paddr == OFS_PUMP_CTRL
		|-> ##2 pump_on == $past(pwdata[BIT_PUMP_EN], 2); endproperty
	property p_disc; $fell(hold_connect) |-> !pre ##1 pre; endproperty
	property p_pre; pre |-> hold_pre_high == sense_pre_low && hold_pre_low == sense_pre_high
		&& hold_pre_high != hold_pre_low; endproperty
	property p_iso; pre |-> !hold_connect; endproperty
	property p_recon; $rose(hold_connect) |-> !pre && $past(pre); endproperty
	property p_conv; conv_start |-> hold_connect && !pre && $past(hold_connect); endproperty
	property p_pulse; conv_start |=> !conv_start; endproperty
	property p_ready; pready |-> psel && $past(psel && penable) && !$past(pready); endproperty
	a_pump: assert property (p_pump) else $error("pump state wrong");
	a_disc: assert property (p_disc) else $error("no precharge after disconnect");
	a_pre: assert property (p_pre) else $error("precharge levels wrong");
	a_iso: assert property (p_iso) else $error("precharge while connected");
	a_recon: assert property (p_recon) else $error("reconnect wrong");
	a_conv: assert property (p_conv) else $error("conversion start wrong");
	a_pulse: assert property (p_pulse) else $error("start not a pulse");
	a_ready: assert property (p_ready) else $error("ready without access");
	c_conv: cover property (conv_start);
	c_pump: cover property ($rose(pump_on));
	c_disc: cover property ($fell(hold_connect));
endmodule
bind adc_pump_cvd_sequencer adc_seq_monitor u_adc_seq_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pump_on(pump_on),
	.hold_connect(hold_connect), .hold_pre_high(hold_pre_high), .hold_pre_low(hold_pre_low),
	.sense_pre_high(sense_pre_high), .sense_pre_low(sense_pre_low), .conv_start(conv_start));
`default_nettype wire

// *** dv/adc_pump_cvd_sequencer_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_pump_cvd_sequencer_bench;
	import adc_aux_pkg::*;
	logic        pclk = 1'h0, presetn, psel, penable, pwrite, pready, pslverr, conv_done;
	logic        pump_on, hold_connect, hold_pre_high, hold_pre_low, sense_pre_high;
	logic        sense_pre_low, conv_start, chan_valid, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [5:0]  chan_sel;
	logic [32:0] q[$];
	logic        lvl[$];
	logic        lv, pre_q = 1'h0;
	int          fail_count = 0, n_tests = 0, nconv = 0;
	adc_pump_cvd_sequencer #(.PUMP_CYCLES(5)) u_adc_pump_cvd_sequencer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conv_done(conv_done), .pump_on(pump_on), .hold_connect(hold_connect),
		.hold_pre_high(hold_pre_high), .hold_pre_low(hold_pre_low),
		.sense_pre_high(sense_pre_high), .sense_pre_low(sense_pre_low),
		.conv_start(conv_start), .chan_sel(chan_sel), .chan_valid(chan_valid), .irq(irq));
	conv_model u_conv_model (.pclk(pclk), .conv_start(conv_start), .conv_done(conv_done));
	initial forever #5 pclk = ~pclk;
	initial
	begin
		#20000;
		fail_count++;
		test_done;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		q.push_back(e);
		xfer(a, 1'h0, 32'h0);
	endtask
	always @(posedge pclk)
	begin
		if (pready && !pwrite)
			chk({pslverr, prdata}, q.pop_front());
		if ((hold_pre_high | hold_pre_low) && !pre_q)
		begin
			lv = lvl.pop_front();
			chk({hold_pre_high, sense_pre_high, hold_connect}, {lv, !lv, 1'h0});
		end
		pre_q <= hold_pre_high | hold_pre_low;
		if (conv_start)
			nconv++;
	end
	initial
	begin
		void'($urandom(71244));
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(OFS_DIV_TIMING, {17'h0, ACQ_RESET, PRE_RESET});
		rd(12'h018, 33'h100000000);
		for (int i = 0; i < 6; i++)
		begin
			v = i ? $urandom : 32'hFFFFFFE3;
			xfer(OFS_CHAN_SEL, 1'h1, v);
			// Outputs trail the register by one edge; look between edges
			@(negedge pclk);
			chk(chan_valid, v[5:0] < 6'h23 || v[5:0] inside {[6'h28:6'h2F]} || v[5:0] > 6'h3A);
			chk(chan_sel, v[5:0]);
			@(posedge pclk);
			rd(OFS_CHAN_SEL, {27'h0, v[5:0]});
		end
		xfer(OFS_PUMP_CTRL, 1'h1, 32'h1);
		rd(OFS_PUMP_CTRL, 33'h1);
		repeat (8) @(posedge pclk);
		rd(OFS_PUMP_CTRL, 33'h3);
		rd(OFS_IRQ_STATUS, 33'h1);
		chk(irq, 1'h0);
		xfer(OFS_PUMP_CTRL, 1'h1, 32'h0);
		rd(OFS_PUMP_CTRL, 33'h0);
		xfer(OFS_IRQ_MASK, 1'h1, 32'h7);
		xfer(OFS_DIV_TIMING, 1'h1, 32'h0302);
		lvl = '{1'h1, 1'h0};
		xfer(OFS_DIV_CTRL, 1'h1, 32'h7);
		// Busy: this start and its level bits must be ignored
		xfer(OFS_DIV_CTRL, 1'h1, 32'h1);
		while (nconv < 2)
			@(posedge pclk);
		repeat (8) @(posedge pclk);
		chk(nconv, 2);
		chk(irq, 1'h1);
		rd(OFS_IRQ_STATUS, 33'h6);
		repeat (2) @(posedge pclk);
		chk(irq, 1'h0);
		// Single-ended pass: one conversion, hold precharged low
		lvl.push_back(1'h0);
		xfer(OFS_DIV_CTRL, 1'h1, 32'h1);
		while (nconv < 3)
			@(posedge pclk);
		repeat (8) @(posedge pclk);
		chk(nconv, 3);
		rd(OFS_IRQ_STATUS, 33'h6);
		test_done;
	end
endmodule
`default_nettype wire
